/* inc/dsgc_params.svh */
// register offsets, reset values, field positions and timing counts of the sensor and gamma block
// assumes inclusion by bare name from the design files
`ifndef DSGC_PARAMS_SVH
`define DSGC_PARAMS_SVH

// ***********************
// register offsets
// ***********************
`define DSGC_OFF_TREF 8'h00
`define DSGC_OFF_TOFF 8'h01
`define DSGC_OFF_TRES 8'h02
`define DSGC_OFF_TUPD 8'h03
`define DSGC_OFF_APD 8'h04
`define DSGC_OFF_VDRV 8'h05
`define DSGC_OFF_RAMP 8'h06
`define DSGC_OFF_BIAS 8'h07
`define DSGC_OFF_DIM 8'h08
`define DSGC_OFF_IMAX 8'h09
`define DSGC_OFF_MODE 8'h0a
`define DSGC_OFF_GSET 8'h0b
`define DSGC_OFF_LIDX 8'h0c
`define DSGC_OFF_LLO 8'h0d
`define DSGC_OFF_LHI 8'h0e
`define DSGC_OFF_LSTAT 8'h0f

// ***********************
// reset values
// ***********************
`define DSGC_RST_TREF 6'h20
`define DSGC_RST_TOFF 8'h00
`define DSGC_RST_TUPD 8'h03
`define DSGC_RST_APD 8'h00
`define DSGC_RST_VDRV 8'hf2
`define DSGC_RST_RAMP 8'h7a
`define DSGC_RST_BIAS 3'h1
`define DSGC_RST_DIM 7'h7f
`define DSGC_RST_IMAX 8'h80
`define DSGC_RST_MODE 4'h0
`define DSGC_RST_STEP 3'h0

// ***********************
// fields and codes
// ***********************
`define DSGC_APD_TSEN 0
`define DSGC_IMAX_COARSE 7:4
`define DSGC_IMAX_FINE 3:0
`define DSGC_MODE_AUTO 4'h0
`define DSGC_MODE_HYBRID 4'h1
`define DSGC_I2C_ADDR_HI 6'h13
`define DSGC_LUT_LAST 8'hff
`define DSGC_I2C_ACK_BIT 4'h8
`define DSGC_I2C_LAST_BIT 4'h7
`define DSGC_MIN_FRAMES 8'h01

`endif

/* inc/dsgc_pkg.sv */
// types shared by the sensor and gamma block
// assumes nothing beyond a SystemVerilog compiler
package dsgc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_REG,
    ST_WDAT,
    ST_RDAT
  } dsgc_i2c_state_t;
  typedef logic [9:0] dsgc_lut_word_t;
endpackage : dsgc_pkg

/* tb/display_sensor_gamma_control_test.sv */
// bench for the sensor and gamma block: host model on i2c, frame timing and converter replies
// assumes the package and parameter header are compiled first
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_count++; $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module display_sensor_gamma_control_test
  import dsgc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, srst = 1'b1, vsync = 1'b0, blank = 1'b0, adc_done = 1'b0, sel = 1'b0;
  logic [7:0] adc_raw = 8'h00, vid = 8'h00, raw, off, dim, imax, drv, ramp, lum, rd_data, exp_v;
  logic sda_out, sda_oe_n, scl, sda_h, rd_valid, conv_start, dim_act, man_en, gs_en, pd;
  logic [5:0] tref, tr;
  logic [2:0] bias, step;
  logic [3:0] crs, fin;
  logic [9:0] lr, lg, lb, w1, w2, g1, g2;
  logic [15:0] lexp;
  int err_count = 0, compares = 0, convs = 0, c0, nacks;
  logic [7:0] exp_q[$];
  wire sda_line = sda_h & (sda_oe_n | sda_out);
  dsgc_sensor_ctrl dsgc_sensor_ctrl_i (.clock(clock), .srst(srst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .serial_addr_sel(sel), .vsync_in(vsync), .blank_in(blank),
    .temp_adc_raw(adc_raw), .temp_adc_done(adc_done), .temp_conv_start(conv_start),
    .temp_sensor_power_down(pd), .temp_ref_divider_out(tref), .pixel_drive_level(drv), .ramp_dac_level(ramp),
    .pixel_bias_level(bias), .max_current_coarse(crs), .max_current_fine(fin), .lum_current_level(lum),
    .dimming_active(dim_act), .cathode_manual_en(man_en), .gamma_step_out(step), .gamma_sensor_en(gs_en),
    .lut_video_in_r(vid), .lut_video_in_g(vid), .lut_video_in_b(vid), .lut_drive_r(lr), .lut_drive_g(lg),
    .lut_drive_b(lb));
  dsgc_host_model host_i (.clock(clock), .sda_line(sda_line), .addr_sel(sel), .scl(scl), .sda(sda_h),
    .rd_valid(rd_valid),
    .rd_data(rd_data), .nacks(nacks));
  // ***********************
  // clock, converter, read monitor
  // ***********************
  initial forever #10 clock = ~clock;
  always @(posedge clock) if (conv_start === 1'b1) begin
    convs++;
    repeat (3) @(negedge clock);
    adc_raw = raw;
    adc_done = 1'b1;
    @(negedge clock);
    adc_done = 1'b0;
  end
  // the note is taken off once, so a mismatch message cannot pop a second one
  always @(posedge clock) if (rd_valid === 1'b1) begin
    exp_v = exp_q.pop_front();
    `CHK(rd_data, exp_v)
  end
  task automatic frames(input int n);
    repeat (n) begin
      vsync = 1'b1;
      repeat (5) @(negedge clock);
      vsync = 1'b0;
      repeat (20) @(negedge clock);
    end
  endtask : frames
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_i.rd(a);
  endtask : rdx
  task stop_test;
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (100000) @(posedge clock);
    err_count++;
    stop_test();
  end
  // ***********************
  // main sequence
  // ***********************
  initial begin
    raw = $urandom(32'h0f4715c0);
    repeat (10) @(negedge clock);
    srst = 1'b0;
    repeat (5) @(negedge clock);
    `CHK(lum, 8'h80)
    rdx(8'h07, 8'h01);
    w1 = $urandom;
    dim = $urandom & 8'h7f;
    imax = $urandom;
    host_i.wr(8'h05, {8'h00, w1[7:0], 8'h7a, 8'h03}, 3);
    `CHK({drv, ramp, bias}, {w1[7:0], 8'h7a, 3'h3})
    host_i.wr(8'h08, {16'h0000, dim, imax}, 2);
    lexp = (16'(imax) * (16'(dim) + 16'h0001)) >> 7;
    `CHK({crs, fin}, imax)
    for (int m = 3; m >= 0; m--) begin
      host_i.wr(8'h0a, 32'(m), 1);
      `CHK({dim_act, man_en}, {m < 2, m >= 2})
      `CHK(lum, (m < 2) ? lexp[7:0] : 8'h00)
      `CHK(gs_en, m == 0)
    end
    host_i.wr(8'h0b, 32'h5, 1);
    `CHK(step, 3'h5)
    frames(1);
    blank = 1'b1;
    @(negedge clock);
    `CHK({gs_en, step}, 4'hd)
    g1 = host_i.norm(1000 + ($urandom % 500), 5000);
    g2 = host_i.norm(1500 + ($urandom % 500), 5000);
    blank = 1'b0;
    host_i.wr(8'h04, 32'h1, 1);
    `CHK(pd, 1'b1)
    c0 = convs;
    frames(4);
    `CHK(convs, c0)
    tr = $urandom;
    off = $urandom;
    raw = $urandom;
    host_i.wr(8'h00, {2'b00, tr, off, 8'hff, 8'h02}, 4);
    `CHK(tref, tr)
    host_i.wr(8'h04, 32'h0, 1);
    frames(1);
    `CHK(convs, c0)
    frames(1);
    `CHK(convs, c0 + 1)
    rdx(8'h02, 8'(raw + off));
    raw = ~raw;
    host_i.wr(8'h04, 32'h1, 1);
    frames(3);
    rdx(8'h02, 8'(~raw + off));
    sel = 1'b1;
    w1 = host_i.interp(254, 128, g1, 255, g2);
    w2 = host_i.interp(4, 8, g1, 16, g2);
    host_i.wr(8'h0c, {8'h00, 8'h00, 8'h01, 8'h00}, 3);
    host_i.wr(8'h0c, {8'h00, 8'h04, w2[7:0], 6'h00, w2[9:8]}, 3);
    host_i.wr(8'h0c, {8'h00, 8'hfe, w1[7:0], 6'h00, w1[9:8]}, 3);
    host_i.wr(8'h0d, {16'h0000, g2[7:0], 6'h00, g2[9:8]}, 2);
    blank = 1'b1;
    repeat (300) @(negedge clock);
    blank = 1'b0;
    vid = 8'hff;
    repeat (2) @(negedge clock);
    `CHK({lr, lg, lb}, {g2, g2, g2})
    vid = 8'hfe;
    repeat (2) @(negedge clock);
    `CHK({lr, lg, lb}, {w1, w1, w1})
    vid = 8'h04;
    repeat (2) @(negedge clock);
    `CHK(lr, w2)
    vid = 8'h00;
    repeat (2) @(negedge clock);
    `CHK(lg, 10'h001)
    `CHK(nacks, 0)
    stop_test();
  end
endmodule : display_sensor_gamma_control_test

/* tb/dsgc_host_model.sv */
// host microcontroller model: drives i2c clock and open-drain data, performs register writes and reads
// assumes sda_line is the resolved wire with a pull-up; bits change a fifth of a bit after scl falls
module dsgc_host_model (
  input wire logic clock,
  input wire logic sda_line,
  input wire logic addr_sel,
  output logic scl,
  output logic sda,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output int nacks
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    rd_valid = 1'b0;
    rd_data = 8'h00;
    nacks = 0;
  end
  // ***********************
  // bus cycles
  // ***********************
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    repeat (4) @(negedge clock);
    sda = b;
    repeat (6) @(negedge clock);
    scl = 1'b1;
    repeat (10) @(negedge clock);
    r = sda_line;
  endtask : bit_io
  task automatic byte_io(input logic [7:0] b, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(1'b1, k);
  endtask : byte_io
  // readings arrive in millivolts; half the array supply is full scale
  function automatic logic [9:0] norm(input int mv, input int supply_mv);
    return 10'((mv * 1023) / (supply_mv / 2));
  endfunction : norm
  // straight line through two table points; outside them it extrapolates
  function automatic logic [9:0] interp(input int x, input int x0, input int y0, input int x1, input int y1);
    return 10'(y0 + ((y1 - y0) * (x - x0)) / (x1 - x0));
  endfunction : interp
  // sda moves only while scl is high for start and stop
  task automatic start();
    sda = 1'b1;
    scl = 1'b1;
    repeat (10) @(negedge clock);
    sda = 1'b0;
    repeat (10) @(negedge clock);
  endtask : start
  task automatic stop();
    bit_io(1'b0, rd_data[0]);
    sda = 1'b0;
    repeat (4) @(negedge clock);
    sda = 1'b1;
    repeat (10) @(negedge clock);
  endtask : stop
  task automatic send(input logic [7:0] b);
    logic [7:0] r;
    logic k;
    byte_io(b, r, k);
    nacks += int'(k);
  endtask : send
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int n);
    start();
    send(8'h4c | {6'h00, addr_sel, 1'b0});
    send(a);
    for (int i = n - 1; i >= 0; i--) send(d[8*i +: 8]);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic [7:0] r;
    logic k;
    start();
    send(8'h4c | {6'h00, addr_sel, 1'b0});
    send(a);
    stop();
    start();
    send(8'h4d | {6'h00, addr_sel, 1'b0});
    byte_io(8'hff, r, k);
    stop();
    rd_data = r;
    rd_valid = 1'b1;
    @(negedge clock);
    rd_valid = 1'b0;
  endtask : rd
endmodule : dsgc_host_model

/* verilog/dsgc_sensor_ctrl.sv */
// sensor, luminance and gamma control of the microdisplay, with its i2c register port
// assumes video timing and lut video share clock; scl, sda, vsync, blank and address pin are asynchronous
`include "dsgc_params.svh"
module dsgc_sensor_ctrl
  import dsgc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic serial_addr_sel,
  input wire logic vsync_in,
  input wire logic blank_in,
  input wire logic [7:0] temp_adc_raw,
  input wire logic temp_adc_done,
  output logic temp_conv_start,
  output logic temp_sensor_power_down,
  output logic [5:0] temp_ref_divider_out,
  output logic [7:0] pixel_drive_level,
  output logic [7:0] ramp_dac_level,
  output logic [2:0] pixel_bias_level,
  output logic [3:0] max_current_coarse,
  output logic [3:0] max_current_fine,
  output logic [7:0] lum_current_level,
  output logic dimming_active,
  output logic cathode_manual_en,
  output logic [2:0] gamma_step_out,
  output logic gamma_sensor_en,
  input wire logic [7:0] lut_video_in_r,
  input wire logic [7:0] lut_video_in_g,
  input wire logic [7:0] lut_video_in_b,
  output logic [9:0] lut_drive_r,
  output logic [9:0] lut_drive_g,
  output logic [9:0] lut_drive_b
);
  // ***********************
  // input synchronisers
  // ***********************
  logic [1:0] scl_q, sda_q, vs_q, bl_q, sel_q;
  logic scl_d, sda_d, vs_d;
  always_ff @(posedge clock) begin
    scl_q <= {scl_q[0], scl_in};
    sda_q <= {sda_q[0], sda_in};
    vs_q <= {vs_q[0], vsync_in};
    bl_q <= {bl_q[0], blank_in};
    sel_q <= {sel_q[0], serial_addr_sel};
    scl_d <= scl_q[1];
    sda_d <= sda_q[1];
    vs_d <= vs_q[1];
  end
  logic scl_rise, scl_fall, i2c_start, i2c_stop, frame_tick, blank_s;
  assign scl_rise = scl_q[1] && !scl_d;
  assign scl_fall = !scl_q[1] && scl_d;
  assign i2c_start = scl_q[1] && scl_d && sda_d && !sda_q[1];
  assign i2c_stop = scl_q[1] && scl_d && !sda_d && sda_q[1];
  assign frame_tick = vs_q[1] && !vs_d;
  assign blank_s = bl_q[1];

  // ***********************
  // i2c slave
  // ***********************
  dsgc_i2c_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh, ptr, next_ptr, rd_data;
  logic drive, next_drive, nack, next_nack;
  logic wr_en, next_wr_en;
  logic [7:0] wr_addr, next_wr_addr, wr_data, next_wr_data;
  logic addr_match;
  // open drain: the pin only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n = !drive;
  assign addr_match = (sh[7:2] == `DSGC_I2C_ADDR_HI) && (sh[1] == sel_q[1]);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_sh = sh;
    next_ptr = ptr;
    next_drive = drive;
    next_nack = nack;
    next_wr_en = 1'b0;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    if (i2c_start) begin
      next_state = ST_ADDR;
      next_cnt = 4'hf; // the scl fall that follows start wraps this to zero, so bit counting starts clean
      next_drive = 1'b0;
    end else if (i2c_stop) begin
      next_state = ST_IDLE;
      next_drive = 1'b0;
    end else if (scl_rise && state != ST_IDLE) begin
      if (cnt != `DSGC_I2C_ACK_BIT && state != ST_RDAT) begin
        next_sh = {sh[6:0], sda_q[1]};
      end
      if (cnt == `DSGC_I2C_ACK_BIT && state == ST_RDAT) begin
        next_nack = sda_q[1];
      end
    end else if (scl_fall && state != ST_IDLE) begin
      if (cnt == `DSGC_I2C_ACK_BIT) begin
        next_cnt = 4'h0;
        next_drive = 1'b0;
        unique case (state)
          ST_ADDR: begin
            if (sh[0]) begin
              next_state = ST_RDAT;
              next_sh = rd_data;
              next_drive = !rd_data[7];
              next_ptr = ptr + 8'h01;
            end else begin
              next_state = ST_REG;
            end
          end
          ST_REG: next_state = ST_WDAT;
          ST_WDAT: next_state = ST_WDAT;
          ST_RDAT: begin
            if (nack) begin
              next_state = ST_IDLE;
            end else begin
              next_sh = rd_data;
              next_drive = !rd_data[7];
              next_ptr = ptr + 8'h01;
            end
          end
          ST_IDLE: next_state = ST_IDLE;
        endcase
      end else begin
        next_cnt = cnt + 4'h1;
        if (state == ST_RDAT) begin
          next_sh = {sh[6:0], 1'b0};
          next_drive = (cnt == `DSGC_I2C_LAST_BIT) ? 1'b0 : !sh[6];
        end else if (cnt == `DSGC_I2C_LAST_BIT) begin
          next_drive = 1'b1;
          unique case (state)
            ST_ADDR: begin
              if (!addr_match) begin
                next_state = ST_IDLE;
                next_drive = 1'b0;
              end
            end
            ST_REG: next_ptr = sh;
            ST_WDAT: begin
              next_wr_en = 1'b1;
              next_wr_addr = ptr;
              next_wr_data = sh;
              next_ptr = ptr + 8'h01;
            end
            ST_IDLE, ST_RDAT: next_drive = 1'b0;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      ptr <= 8'h00;
      drive <= 1'b0;
      nack <= 1'b0;
      wr_en <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      sh <= next_sh;
      ptr <= next_ptr;
      drive <= next_drive;
      nack <= next_nack;
      wr_en <= next_wr_en;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
    end
  end

  // ***********************
  // control registers
  // ***********************
  logic [5:0] temp_ref_divider;
  logic [7:0] temp_offset_trim, temp_update_period, analog_power_down_reg, temp_result;
  logic [7:0] pixel_drive_max_level, ramp_dac_max_level, max_current_setting, lut_index, lut_lo;
  logic [2:0] pixel_bias_current, gamma_setup_reg;
  logic [6:0] brightness_dimming;
  logic [3:0] cathode_regulation_mode;
  logic buffer_full;

  always_ff @(posedge clock) begin
    if (srst) begin
      temp_ref_divider <= `DSGC_RST_TREF;
      temp_offset_trim <= `DSGC_RST_TOFF;
      temp_update_period <= `DSGC_RST_TUPD;
      analog_power_down_reg <= `DSGC_RST_APD;
      pixel_drive_max_level <= `DSGC_RST_VDRV;
      ramp_dac_max_level <= `DSGC_RST_RAMP;
      pixel_bias_current <= `DSGC_RST_BIAS;
      brightness_dimming <= `DSGC_RST_DIM;
      max_current_setting <= `DSGC_RST_IMAX;
      cathode_regulation_mode <= `DSGC_RST_MODE;
      gamma_setup_reg <= `DSGC_RST_STEP;
    end else if (wr_en) begin
      // the result register has no write path at all
      unique case (wr_addr)
        `DSGC_OFF_TREF: temp_ref_divider <= wr_data[5:0];
        `DSGC_OFF_TOFF: temp_offset_trim <= wr_data;
        `DSGC_OFF_TUPD: temp_update_period <= wr_data;
        `DSGC_OFF_APD: analog_power_down_reg <= wr_data;
        `DSGC_OFF_VDRV: pixel_drive_max_level <= wr_data;
        `DSGC_OFF_RAMP: ramp_dac_max_level <= wr_data;
        `DSGC_OFF_BIAS: pixel_bias_current <= wr_data[2:0];
        `DSGC_OFF_DIM: brightness_dimming <= wr_data[6:0];
        `DSGC_OFF_IMAX: max_current_setting <= wr_data;
        `DSGC_OFF_MODE: cathode_regulation_mode <= wr_data[3:0];
        `DSGC_OFF_GSET: gamma_setup_reg <= wr_data[2:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (ptr)
      `DSGC_OFF_TREF: rd_data = {2'h0, temp_ref_divider};
      `DSGC_OFF_TOFF: rd_data = temp_offset_trim;
      `DSGC_OFF_TRES: rd_data = temp_result;
      `DSGC_OFF_TUPD: rd_data = temp_update_period;
      `DSGC_OFF_APD: rd_data = analog_power_down_reg;
      `DSGC_OFF_VDRV: rd_data = pixel_drive_max_level;
      `DSGC_OFF_RAMP: rd_data = ramp_dac_max_level;
      `DSGC_OFF_BIAS: rd_data = {5'h00, pixel_bias_current};
      `DSGC_OFF_DIM: rd_data = {1'b0, brightness_dimming};
      `DSGC_OFF_IMAX: rd_data = max_current_setting;
      `DSGC_OFF_MODE: rd_data = {4'h0, cathode_regulation_mode};
      `DSGC_OFF_GSET: rd_data = {5'h00, gamma_setup_reg};
      `DSGC_OFF_LIDX: rd_data = lut_index;
      `DSGC_OFF_LLO: rd_data = lut_lo;
      `DSGC_OFF_LSTAT: rd_data = {7'h00, buffer_full};
      default: rd_data = 8'h00;
    endcase
  end

  // ***********************
  // temperature
  // ***********************
  assign temp_sensor_power_down = analog_power_down_reg[`DSGC_APD_TSEN];
  assign temp_ref_divider_out = temp_ref_divider;
  dsgc_temp_unit u_temp (
    .clock(clock),
    .srst(srst),
    .frame_tick(frame_tick),
    .power_down(temp_sensor_power_down),
    .update_period(temp_update_period),
    .offset_trim(temp_offset_trim),
    .adc_raw(temp_adc_raw),
    .adc_done(temp_adc_done),
    .conv_start(temp_conv_start),
    .result(temp_result)
  );

  // ***********************
  // luminance and gamma
  // ***********************
  // 128 linear steps: code 7f gives the full maximum, code 0 a small floor
  function automatic logic [7:0] dsgc_dim_scale(input logic [7:0] imax, input logic [6:0] dim);
    logic [15:0] prod;
    prod = 16'(imax) * 16'({1'b0, dim} + 8'h01);
    return prod[14:7];
  endfunction : dsgc_dim_scale

  logic dim_ok, next_lum_ok;
  logic [7:0] next_lum;
  assign dim_ok = (cathode_regulation_mode == `DSGC_MODE_AUTO)
               || (cathode_regulation_mode == `DSGC_MODE_HYBRID);
  assign pixel_drive_level = pixel_drive_max_level;
  assign ramp_dac_level = ramp_dac_max_level;
  assign pixel_bias_level = pixel_bias_current;
  assign max_current_coarse = max_current_setting[`DSGC_IMAX_COARSE];
  assign max_current_fine = max_current_setting[`DSGC_IMAX_FINE];
  assign gamma_step_out = gamma_setup_reg;

  always_comb begin
    next_lum = 8'h00;
    next_lum_ok = dim_ok;
    if (dim_ok) begin
      next_lum = dsgc_dim_scale(max_current_setting, brightness_dimming);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      lum_current_level <= 8'h00;
      dimming_active <= 1'b0;
      cathode_manual_en <= 1'b0;
      gamma_sensor_en <= 1'b0;
    end else begin
      lum_current_level <= next_lum;
      dimming_active <= next_lum_ok;
      cathode_manual_en <= !next_lum_ok;
      gamma_sensor_en <= (cathode_regulation_mode == `DSGC_MODE_AUTO);
    end
  end

  // ***********************
  // lookup tables
  // ***********************
  dsgc_lut_word_t buf_tab [256];
  dsgc_lut_word_t dp_r [256];
  dsgc_lut_word_t dp_g [256];
  dsgc_lut_word_t dp_b [256];
  logic [7:0] next_lut_index, next_lut_lo, copy_idx, next_copy_idx;
  logic next_full, buf_we, dp_we;

  always_comb begin
    next_lut_index = lut_index;
    next_lut_lo = lut_lo;
    next_full = buffer_full;
    next_copy_idx = copy_idx;
    buf_we = 1'b0;
    dp_we = 1'b0;
    if (wr_en && wr_addr == `DSGC_OFF_LIDX) begin
      next_lut_index = wr_data;
    end
    if (wr_en && wr_addr == `DSGC_OFF_LLO) begin
      next_lut_lo = wr_data;
    end
    // high byte completes a word; refused while the buffer waits for blanking
    if (wr_en && wr_addr == `DSGC_OFF_LHI && !buffer_full) begin
      buf_we = 1'b1;
      next_lut_index = lut_index + 8'h01;
      next_full = (lut_index == `DSGC_LUT_LAST);
    end
    if (buffer_full && blank_s) begin
      dp_we = 1'b1;
      next_copy_idx = copy_idx + 8'h01;
      next_full = (copy_idx != `DSGC_LUT_LAST);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      lut_index <= 8'h00;
      lut_lo <= 8'h00;
      buffer_full <= 1'b0;
      copy_idx <= 8'h00;
    end else begin
      lut_index <= next_lut_index;
      lut_lo <= next_lut_lo;
      buffer_full <= next_full;
      copy_idx <= next_copy_idx;
    end
  end

  // copy one entry per clock; a copy cut short by active video resumes next blanking
  always_ff @(posedge clock) begin
    if (buf_we) begin
      buf_tab[lut_index] <= {wr_data[1:0], lut_lo};
    end
    if (dp_we) begin
      dp_r[copy_idx] <= buf_tab[copy_idx];
      dp_g[copy_idx] <= buf_tab[copy_idx];
      dp_b[copy_idx] <= buf_tab[copy_idx];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      lut_drive_r <= 10'h000;
      lut_drive_g <= 10'h000;
      lut_drive_b <= 10'h000;
    end else begin
      lut_drive_r <= dp_r[lut_video_in_r];
      lut_drive_g <= dp_g[lut_video_in_g];
      lut_drive_b <= dp_b[lut_video_in_b];
    end
  end

  // ***********************
  // checks
  // ***********************
  sequence s_addr_hit;
    state == ST_ADDR && scl_fall && cnt == `DSGC_I2C_LAST_BIT && addr_match && !i2c_start && !i2c_stop;
  endsequence
  sequence s_ack_low;
    !sda_oe_n;
  endsequence
  a_i2c_addr_ack: assert property (@(posedge clock) disable iff (srst) s_addr_hit |=> s_ack_low)
    else $error("matching address not acknowledged");
  a_bias_reset: assert property (@(posedge clock) srst |=> pixel_bias_level == 3'h1)
    else $error("bias field reset value wrong");
  a_dim_manual: assert property (@(posedge clock) disable iff (srst)
    !dim_ok |=> !dimming_active && cathode_manual_en && lum_current_level == 8'h00)
    else $error("dimming active in manual cathode mode");
  a_dim_full: assert property (@(posedge clock) disable iff (srst)
    dim_ok && brightness_dimming == 7'h7f |=> lum_current_level == $past(max_current_setting))
    else $error("full dimming code not at maximum");
  a_gamma_mode: assert property (@(posedge clock) disable iff (srst)
    gamma_sensor_en |-> $past(cathode_regulation_mode) == `DSGC_MODE_AUTO)
    else $error("gamma sensor enabled outside mode 0");
  a_temp_wr_ignore: assert property (@(posedge clock) disable iff (srst)
    wr_en && wr_addr == `DSGC_OFF_TRES && !temp_adc_done |=> $stable(temp_result))
    else $error("write disturbed temperature result");
  a_copy_blank: assert property (@(posedge clock) disable iff (srst)
    $fell(buffer_full) |-> $past(dp_we) && copy_idx == 8'h00) else $error("lookup copy ended early");
endmodule : dsgc_sensor_ctrl

/* verilog/dsgc_temp_unit.sv */
// temperature conversion scheduler: frames counted, result trimmed and held
// assumes frame_tick is a one-cycle pulse on clock and the converter answers with adc_done
`include "dsgc_params.svh"
module dsgc_temp_unit
  import dsgc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic frame_tick,
  input wire logic power_down,
  input wire logic [7:0] update_period,
  input wire logic [7:0] offset_trim,
  input wire logic [7:0] adc_raw,
  input wire logic adc_done,
  output logic conv_start,
  output logic [7:0] result
);
  logic [7:0] frames;
  logic [7:0] next_frames;
  logic next_conv_start;
  logic [7:0] next_result;
  logic [7:0] period;

  // a period of zero is raised to the one-frame minimum, so it acts as one frame
  assign period = (update_period < `DSGC_MIN_FRAMES) ? `DSGC_MIN_FRAMES : update_period;

  always_comb begin
    next_frames = frames;
    next_conv_start = 1'b0;
    next_result = result;
    if (power_down) begin
      next_frames = 8'h00;
    end else if (frame_tick) begin
      if (frames + 8'h01 >= period) begin
        next_frames = 8'h00;
        next_conv_start = 1'b1;
      end else begin
        next_frames = frames + 8'h01;
      end
    end
    if (adc_done && !power_down) begin
      next_result = adc_raw + offset_trim;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      frames <= 8'h00;
      conv_start <= 1'b0;
      result <= 8'h00;
    end else begin
      frames <= next_frames;
      conv_start <= next_conv_start;
      result <= next_result;
    end
  end

  // ***********************
  // checks
  // ***********************
  a_pd_no_start: assert property (@(posedge clock) disable iff (srst) power_down |=> !conv_start)
    else $error("conversion started while sensor powered down");
  a_result_load: assert property (@(posedge clock) disable iff (srst)
    adc_done && !power_down |=> result == 8'($past(adc_raw) + $past(offset_trim)))
    else $error("temperature result not trimmed and loaded");
  a_result_hold: assert property (@(posedge clock) disable iff (srst)
    !(adc_done && !power_down) |=> $stable(result))
    else $error("temperature result changed without a conversion");
  a_start_frame: assert property (@(posedge clock) disable iff (srst)
    conv_start |-> $past(frame_tick))
    else $error("conversion start not on a frame boundary");
endmodule : dsgc_temp_unit
